// ---- secondary_serial_master_port.sv ----
// secondary serial master port: register file, serial engine and pin drivers
//
// Notes on behaviour
// - wired-or bit selects open-drain outputs
// - clock select field sets serial rate
// - four bits enable the four inputs
// - read channel field picks captured input
// - read-only busy flag while transfer runs
// - phase bit: data on or before edge
// - control, command or data write during transfer sets collision flag
// - polarity bit picks change and valid edges
// - timeout flag set when transfer times out
// - request bit starts, hardware clears when done
// - byte count sets bytes per transfer
// - five enables gate the chip selects
// - command register: sixteen bits, upper reserved
// - data register: three bytes, upper first
// - control resets to 1.024 MHz, all inputs
`timescale 1ns/100ps
`include "serial2_consts.svh"

module secondary_serial_master_port #(
  parameter int unsigned TIMEOUT_CYC = `TIMEOUT_US * `CLK_MHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // serial pins
  output logic port_serial_clock_o,
  output logic port_serial_clock_oe_n,
  output logic sdo_o,
  output logic sdo_oe_n,
  output logic [4:0] sel_n_o,
  output logic [4:0] sel_oe_n,
  input wire logic [3:0] serial_in,
  // interrupt
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write into a 24-bit register
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [23:0] res;
    res = old;
    for (int i = 0; i < 3; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // address decode shared by both channels
  function automatic logic idx_hit(input logic [9:0] idx);
    logic hit;
    hit = 1'h0;
    if (idx == `IDX_CTRL) begin
      hit = 1'h1;
    end else if (idx == `IDX_CMD) begin
      hit = 1'h1;
    end else if (idx == `IDX_DATA) begin
      hit = 1'h1;
    end else if (idx == `IDX_IRQ_ST) begin
      hit = 1'h1;
    end else if (idx == `IDX_IRQ_MASK) begin
      hit = 1'h1;
    end
    return hit;
  endfunction

  // half serial-clock period in mclk cycles, rounded down
  function automatic logic [10:0] half_len(input logic [2:0] code);
    logic [10:0] n;
    case (code)
      3'h4: n = 11'(`CLK_KHZ / (2 * `SCK_KHZ_2048));
      3'h3: n = 11'(`CLK_KHZ / (2 * `SCK_KHZ_1024));
      3'h2: n = 11'(`CLK_KHZ / (2 * `SCK_KHZ_512));
      3'h1: n = 11'(`CLK_KHZ / (2 * `SCK_KHZ_128));
      default: n = 11'(`CLK_KHZ / (2 * `SCK_KHZ_32));
    endcase
    return n;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [23:0] ctrl_r, cmd_r, data_r;
  logic [2:0] irq_st_r, irq_mask_r;
  logic req_r, coll_r, tmo_r;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [9:0] aw_idx_r;
  logic [31:0] wdata_r, rdata_r, rd_nxt;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_do, wr_port, wr_ok, start, busy, tick, done_p, abort;
  logic [23:0] ctrl_nxt, cmd_nxt;
  serial2_pkg::xfer_state_t state_r;
  logic [10:0] half_cnt_r;
  logic [6:0] edge_r, last_edge_r;
  logic [39:0] tx_r;
  logic [23:0] rx_r;
  logic sck_r, sdo_r;
  logic [4:0] sel_n_r;
  logic [31:0] tmo_cnt_r;
  logic [3:0] si_meta_r, si_sync_r, si_en, in_en;
  logic si_bit;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  assign awready = !aw_held_r;
  assign wready = !w_held_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wr_do = aw_held_r && w_held_r && !bvalid_r;
  // port registers are locked while a transfer is on the wire
  assign wr_port = wr_do && (aw_idx_r == `IDX_CTRL || aw_idx_r == `IDX_CMD ||
                             aw_idx_r == `IDX_DATA);
  assign wr_ok = wr_port && !busy;

  // address and data are taken in either order, then the write acts once
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r <= 1'h0;
      w_held_r <= 1'h0;
      aw_idx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'h0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (awvalid && !aw_held_r) begin
        aw_held_r <= 1'h1;
        aw_idx_r <= (awaddr[11:10] == 2'h0) ? awaddr[9:0] >> 2 : 10'h3FF;
      end
      if (wvalid && !w_held_r) begin
        w_held_r <= 1'h1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_do) begin
        aw_held_r <= 1'h0;
        w_held_r <= 1'h0;
        bvalid_r <= 1'h1;
        bresp_r <= idx_hit(aw_idx_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'h0;
      end
    end
  end

  // read view; reserved bits read as zero
  always_comb begin
    rd_nxt = '0;
    if ((araddr[11:2] >> 0) == `IDX_CTRL) begin
      rd_nxt[23:0] = {ctrl_r[23:14], busy, ctrl_r[12], coll_r, ctrl_r[10], tmo_r, req_r,
                      ctrl_r[7:0]};
    end else if (araddr[11:2] == `IDX_CMD) begin
      rd_nxt[23:0] = {8'h00, cmd_r[15:0]};
    end else if (araddr[11:2] == `IDX_DATA) begin
      rd_nxt[23:0] = data_r;
    end else if (araddr[11:2] == `IDX_IRQ_ST) begin
      rd_nxt[2:0] = irq_st_r;
    end else if (araddr[11:2] == `IDX_IRQ_MASK) begin
      rd_nxt[2:0] = irq_mask_r;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'h0;
      rdata_r <= '0;
      rresp_r <= `RESP_OKAY;
    end else if (arvalid && !rvalid_r) begin
      rvalid_r <= 1'h1;
      rdata_r <= rd_nxt;
      rresp_r <= idx_hit(araddr[11:2]) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port registers

  assign ctrl_nxt = merge(ctrl_r, wdata_r, wstrb_r);
  assign cmd_nxt = merge(cmd_r, wdata_r, wstrb_r);
  assign start = wr_ok && aw_idx_r == `IDX_CTRL && wstrb_r[1] && ctrl_nxt[`B_REQ];

  // configuration, command and data; capture of read data at the end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `CTRL_RST;
      cmd_r <= '0;
      data_r <= '0;
    end else begin
      if (wr_ok && aw_idx_r == `IDX_CTRL) begin
        ctrl_r <= ctrl_nxt & `CTRL_WMASK;
      end
      if (wr_ok && aw_idx_r == `IDX_CMD) begin
        cmd_r <= {8'h00, cmd_nxt[15:0]};
      end
      if (wr_ok && aw_idx_r == `IDX_DATA) begin
        data_r <= merge(data_r, wdata_r, wstrb_r);
      end else if (done_p && in_en[ctrl_r[`F_RD_SEL]]) begin
        data_r <= rx_r;
      end
    end
  end

  // request and flags; a hardware set beats a software clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req_r <= 1'h0;
      coll_r <= 1'h0;
      tmo_r <= 1'h0;
    end else begin
      if (start) begin
        req_r <= 1'h1;
      end else if (done_p || abort) begin
        req_r <= 1'h0;
      end
      if (wr_port && busy) begin
        coll_r <= 1'h1;
      end else if (wr_ok && aw_idx_r == `IDX_CTRL && wstrb_r[1] && !ctrl_nxt[`B_COLL]) begin
        coll_r <= 1'h0;
      end
      if (abort) begin
        tmo_r <= 1'h1;
      end else if (wr_ok && aw_idx_r == `IDX_CTRL && wstrb_r[1] && !ctrl_nxt[`B_TMO]) begin
        tmo_r <= 1'h0;
      end
    end
  end

  // sticky interrupt status, write one to clear; set wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_st_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~((wr_do && aw_idx_r == `IDX_IRQ_ST && wstrb_r[0]) ?
                               wdata_r[2:0] : 3'h0)) |
                  {wr_port && busy, abort, done_p};
      if (wr_do && aw_idx_r == `IDX_IRQ_MASK && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[2:0];
      end
    end
  end

  assign irq = |(irq_st_r & irq_mask_r);

  //////////////////////////////////////////////////////////////////////////////
  // serial inputs: two flops before any use

  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        si_meta_r[g] <= 1'h0;
        si_sync_r[g] <= 1'h0;
      end else begin
        si_meta_r[g] <= serial_in[g];
        si_sync_r[g] <= si_meta_r[g];
      end
    end
  end

  // capture is gated by the enable bit, not by the level on the line
  assign in_en = ctrl_r[`F_INEN];
  assign si_en = si_sync_r & ctrl_r[`F_INEN];
  assign si_bit = si_en[ctrl_r[`F_RD_SEL]];

  //////////////////////////////////////////////////////////////////////////////
  // serial engine

  assign busy = state_r != serial2_pkg::ST_IDLE;
  assign tick = half_cnt_r == 11'h000;
  assign done_p = state_r == serial2_pkg::ST_HOLD && tick;
  assign abort = busy && tmo_cnt_r >= TIMEOUT_CYC;

  // half-period divider; reloads from the rate field
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      half_cnt_r <= '0;
    end else if (!busy || tick) begin
      // the setup half period already uses the rate written with the request
      half_cnt_r <= half_len(start ? ctrl_nxt[`F_RATE] : ctrl_r[`F_RATE]) - 11'h001;
    end else begin
      half_cnt_r <= half_cnt_r - 11'h001;
    end
  end

  // watchdog on a transfer that never ends
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tmo_cnt_r <= '0;
    end else if (!busy) begin
      tmo_cnt_r <= '0;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + 32'h1;
    end
  end

  // select, shift command then data msb first, deselect
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= serial2_pkg::ST_IDLE;
      sck_r <= 1'h0;
      sdo_r <= 1'h0;
      sel_n_r <= 5'h1F;
      tx_r <= '0;
      rx_r <= '0;
      edge_r <= '0;
      last_edge_r <= '0;
    end else if (abort) begin
      state_r <= serial2_pkg::ST_IDLE;
      sel_n_r <= 5'h1F;
      sck_r <= ctrl_r[`B_CPOL];
    end else begin
      case (state_r)
        serial2_pkg::ST_IDLE: begin
          sck_r <= ctrl_r[`B_CPOL];
          if (start) begin
            state_r <= serial2_pkg::ST_SETUP;
            // idle level follows the polarity written with the request
            sck_r <= ctrl_nxt[`B_CPOL];
            sel_n_r <= ~ctrl_nxt[`F_SEL];
            // first bit is out before the first edge; later bits follow the change edge
            sdo_r <= cmd_r[15];
            // phase 1 presents the msb again on the first change edge, so keep it queued
            tx_r <= ctrl_nxt[`B_CPHA] ? {cmd_r[15:0], data_r} :
                    {cmd_r[14:0], data_r, 1'h0};
            edge_r <= '0;
            if (ctrl_nxt[`F_BCNT] == 3'h0) begin
              last_edge_r <= 7'h0F;
            end else if (ctrl_nxt[`F_BCNT] > `MAX_BYTES) begin
              last_edge_r <= 7'h4F;
            end else begin
              last_edge_r <= {ctrl_nxt[`F_BCNT], 4'h0} - 7'h01;
            end
          end
        end
        serial2_pkg::ST_SETUP: begin
          if (tick) begin
            state_r <= serial2_pkg::ST_SHIFT;
          end
        end
        serial2_pkg::ST_SHIFT: begin
          if (tick) begin
            sck_r <= ~sck_r;
            edge_r <= edge_r + 7'h01;
            if (edge_r[0] == ctrl_r[`B_CPHA]) begin
              rx_r <= {rx_r[22:0], si_bit};
            end else if (edge_r != last_edge_r) begin
              sdo_r <= ctrl_r[`B_CPHA] ? tx_r[39] : tx_r[39];
              tx_r <= {tx_r[38:0], 1'h0};
            end
            if (ctrl_r[`B_CPHA] && edge_r == 7'h00) begin
              sdo_r <= cmd_r[15];
            end
            if (edge_r == last_edge_r) begin
              state_r <= serial2_pkg::ST_HOLD;
            end
          end
        end
        serial2_pkg::ST_HOLD: begin
          if (tick) begin
            sel_n_r <= 5'h1F;
            state_r <= serial2_pkg::ST_IDLE;
          end
        end
        default: state_r <= serial2_pkg::ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers: open drain only pulls low, enables are active low

  assign port_serial_clock_o = ctrl_r[`B_WIRED] ? 1'h0 : sck_r;
  assign port_serial_clock_oe_n = ctrl_r[`B_WIRED] ? sck_r : 1'h0;
  assign sdo_o = ctrl_r[`B_WIRED] ? 1'h0 : sdo_r;
  assign sdo_oe_n = ctrl_r[`B_WIRED] ? sdo_r : 1'h0;
  assign sel_n_o = ctrl_r[`B_WIRED] ? 5'h00 : sel_n_r;
  assign sel_oe_n = ctrl_r[`B_WIRED] ? sel_n_r : 5'h00;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_begin;
    start ##1 state_r == serial2_pkg::ST_SETUP;
  endsequence

  sequence s_finish;
    state_r == serial2_pkg::ST_HOLD && tick && !abort;
  endsequence

  a_idle_clock_level: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == serial2_pkg::ST_IDLE && !abort |=>
    sck_r == $past(start ? ctrl_nxt[`B_CPOL] : ctrl_r[`B_CPOL]))
    else $error("idle serial clock not at polarity level");

  a_open_drain_pins: assert property (@(posedge mclk) disable iff (!resetn)
    ctrl_r[`B_WIRED] |-> sdo_o == 1'h0 && sel_oe_n == sel_n_r && !port_serial_clock_o)
    else $error("open drain pin driven high");

  a_start_selects: assert property (@(posedge mclk) disable iff (!resetn)
    s_begin |-> busy && sel_n_r == ~ctrl_r[`F_SEL])
    else $error("chip selects not taken from enables");

  a_busy_on_start: assert property (@(posedge mclk) disable iff (!resetn)
    start |=> busy && req_r)
    else $error("in progress flag not raised");

  a_request_cleared: assert property (@(posedge mclk) disable iff (!resetn)
    s_finish |=> !req_r && !busy && sel_n_r == 5'h1F)
    else $error("request not cleared at completion");

  a_collision_flag: assert property (@(posedge mclk) disable iff (!resetn)
    wr_port && busy |=> coll_r && $stable(cmd_r) && irq_st_r[`IRQ_COLL])
    else $error("collision not flagged");

  a_timeout_flag: assert property (@(posedge mclk) disable iff (!resetn)
    abort |=> tmo_r && !busy ##1 !busy)
    else $error("timeout not flagged");

  a_first_bit_cmd: assert property (@(posedge mclk) disable iff (!resetn)
    start |=> sdo_r == $past(cmd_r[15]))
    else $error("first bit is not command msb");

  a_clock_rate_hold: assert property (@(posedge mclk) disable iff (!resetn)
    state_r == serial2_pkg::ST_SHIFT && !tick && !abort |=> $stable(sck_r))
    else $error("serial clock moved between ticks");

endmodule

// ---- serial2_consts.svh ----
// register indices, field positions, reset values and timing for the serial port
`ifndef SERIAL2_CONSTS_SVH
`define SERIAL2_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_CTRL 10'h010
`define IDX_CMD 10'h011
`define IDX_DATA 10'h012
`define IDX_IRQ_ST 10'h013
`define IDX_IRQ_MASK 10'h014
// control register fields
`define B_WIRED 23
`define F_RATE 22:20
`define F_INEN 19:16
`define F_RD_SEL 15:14
`define B_BUSY 13
`define B_CPHA 12
`define B_COLL 11
`define B_CPOL 10
`define B_TMO 9
`define B_REQ 8
`define F_BCNT 7:5
`define F_SEL 4:0
`define CTRL_RST 24'h3F00E0
`define CTRL_WMASK 24'hFFD4FF
// interrupt status bits
`define IRQ_DONE 0
`define IRQ_TMO 1
`define IRQ_COLL 2
// clock and timing
`define CLK_KHZ 100000
`define CLK_MHZ 100
`define SCK_KHZ_2048 2048
`define SCK_KHZ_1024 1024
`define SCK_KHZ_512 512
`define SCK_KHZ_128 128
`define SCK_KHZ_32 32
`define TIMEOUT_US 2000
`define MAX_BYTES 3'h5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- serial2_pkg.sv ----
// types shared by the secondary serial master port
package serial2_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD} xfer_state_t;
endpackage

// ---- serial2_slave_model.sv ----
// behavioural serial slave that answers the port on its four inputs
`timescale 1ns/100ps
module serial2_slave_model (
  // resolved link wires
  input wire logic sck_w,
  input wire logic sdo_w,
  input wire logic [4:0] sel_w,
  // mode and answer set by the bench
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [39:0] reply,
  // answer lines and what was seen
  output logic [3:0] serial_in,
  output logic [39:0] rx,
  output logic [7:0] nbits,
  output logic [4:0] sel_cap,
  output logic [63:0] half_ns
);
  logic [39:0] sr;
  logic started;
  logic drv;
  logic [63:0] last_t;
  wire any_sel = ~&sel_w;

  // inputs one and three carry the answer, two and four its inverse
  assign serial_in = {~drv, drv, ~drv, drv};

  initial begin
    {sr, rx, nbits, sel_cap, half_ns, last_t, started, drv} = '0;
  end

  ////////////////////////////////////////////////////////////
  // frame start loads the answer; with phase 1 the line is wrong until the first edge
  always @(posedge any_sel) begin
    sr = reply;
    rx = '0;
    nbits = '0;
    started = !cpha;
    drv = started ? sr[39] : ~sr[39];
  end

  // a released line must not look valid, so flip the last value
  always @(negedge any_sel) drv = ~drv;

  // sample on the valid edge, shift the answer on the change edge
  always @(sck_w) begin
    half_ns = $time - last_t;
    last_t = $time;
    if (any_sel) begin
      if ((sck_w != cpol) != cpha) begin
        rx = {rx[38:0], sdo_w};
        nbits = nbits + 8'h01;
        sel_cap = sel_w;
      end else begin
        if (started) sr = sr << 1;
        started = 1'b1;
        drv = sr[39];
      end
    end
  end
endmodule

// ---- tb_secondary_serial_master_port.sv ----
// self-checking bench: axi4-lite register access and transfers into a slave model
`timescale 1ns/100ps
`include "serial2_consts.svh"
module tb_secondary_serial_master_port;
  localparam int TMO = 20000;
  localparam logic [11:0] A_CTRL = {`IDX_CTRL, 2'h0};
  localparam logic [11:0] A_CMD = {`IDX_CMD, 2'h0};
  localparam logic [11:0] A_DAT = {`IDX_DATA, 2'h0};
  localparam logic [11:0] A_ST = {`IDX_IRQ_ST, 2'h0};
  localparam logic [11:0] A_MASK = {`IDX_IRQ_MASK, 2'h0};
  localparam logic [1:0] OK = `RESP_OKAY;
  logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready, cpol, cpha;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [39:0] reply;
  wire awready, wready, bvalid, arready, rvalid, irq, sck_o, sck_oe_n, sdo_o, sdo_oe_n;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [4:0] sel_n_o, sel_oe_n, sel_cap;
  wire [3:0] serial_in;
  wire [39:0] rx;
  wire [7:0] nbits;
  wire [63:0] half_ns;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [23:0] cfgs [4] = '{24'h4F00BF, 24'hCFD465, 24'h2F4490, 24'h109002};
  int hs [4] = '{24, 24, 97, 390};

  // open-drain lines float high, so a wire is low only where driven low
  wire sck_w = sck_oe_n | sck_o;
  wire sdo_w = sdo_oe_n | sdo_o;
  wire [4:0] sel_w = sel_oe_n | sel_n_o;

  secondary_serial_master_port #(.TIMEOUT_CYC(TMO)) i_secondary_serial_master_port (
    .mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .port_serial_clock_o(sck_o), .port_serial_clock_oe_n(sck_oe_n),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sel_n_o(sel_n_o), .sel_oe_n(sel_oe_n),
    .serial_in(serial_in), .irq(irq));

  serial2_slave_model i_serial2_slave_model (
    .sck_w(sck_w), .sdo_w(sdo_w), .sel_w(sel_w), .cpol(cpol), .cpha(cpha), .reply(reply),
    .serial_in(serial_in), .rx(rx), .nbits(nbits), .sel_cap(sel_cap), .half_ns(half_ns));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////
  // shared compare, bus cycles and verdict
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    chk({n < 50, bresp}, {1'b1, er}, "write response");
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    chk({n < 50, rresp}, {1'b1, er}, "read response");
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  // bounded wait; the slowest complete transfer is well inside it
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 25000) begin
      @(posedge mclk);
      n++;
    end
    chk(irq, 1'b1, "interrupt");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard well above the longest expected run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [23:0] cfg, dat, expd;
    logic [15:0] cmd;
    logic [39:0] r;
    int bits;
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cpol, cpha} = '0;
    {awaddr, araddr, wdata} = '0;
    reply = 40'h9D2B6E41C7;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    // reset values, then an unmapped place
    rd(A_CTRL, OK, v);
    chk(v, 32'h003F00E0, "control after reset");
    rd(A_CMD, OK, v);
    chk(v, '0, "command after reset");
    rd(A_DAT, OK, v);
    chk(v, '0, "data after reset");
    chk(irq, 1'b0, "irq after reset");
    wr(12'h054, 32'h00FFFFFF, `RESP_SLVERR);
    rd(12'h054, `RESP_SLVERR, v);
    chk(v, '0, "unmapped read");
    wr(A_MASK, 32'h00000007, OK);
    $display("test reset and map done");
    // one transfer per mode, rate, width and select set; port registers written only when idle, except the command write in pass 0 that tests collision
    for (int i = 0; i < 4; i++) begin
      cfg = cfgs[i];
      cmd = 16'hA53C ^ {4{i[3:0]}};
      dat = 24'hC3817E ^ {6{i[3:0]}};
      bits = cfg[7:5] == 3'h0 ? 8 : 8 * cfg[7:5];
      wr(A_CMD, {8'h00, 8'hFF, cmd}, OK);
      wr(A_DAT, {8'h00, dat}, OK);
      cpol <= cfg[10];
      cpha <= cfg[12];
      // settle polarity and pin mode while deselected, so the frame opens clean
      wr(A_CTRL, {8'h00, cfg}, OK);
      wr(A_CTRL, {8'h00, cfg | 24'h000100}, OK);
      rd(A_CTRL, OK, v);
      chk(v[13:8] & 6'h21, 6'h21, "busy and request while running");
      if (i == 0) begin
        wr(A_CMD, 32'h00001234, OK);
        rd(A_ST, OK, v);
        chk(v, 32'h00000004, "collision status");
        wr(A_ST, 32'h00000004, OK);
      end
      wait_irq();
      chk(rx, {cmd, dat} >> (40 - bits), "bits on the wire");
      chk(nbits, bits, "bit count");
      chk(sel_cap, 5'(~cfg[4:0]), "selects during transfer");
      chk(half_ns, hs[i] * 10, "half period");
      rd(A_CTRL, OK, v);
      chk(v, cfg | (i == 0 ? 24'h000800 : 24'h000000), "control after");
      rd(A_CMD, OK, v);
      chk(v, cmd, "command kept");
      r = reply >> (40 - bits);
      expd = cfg[16 + cfg[15:14]] ? (cfg[14] ? ~r[23:0] : r[23:0]) : dat;
      rd(A_DAT, OK, v);
      chk(v, expd, "captured data");
      rd(A_ST, OK, v);
      chk(v, 32'h00000001, "status");
      wr(A_ST, 32'h00000007, OK);
      chk(irq, 1'b0, "irq cleared");
      if (cfg[23]) chk({sck_o, sdo_o, sel_n_o}, '0, "open drain levels");
      else chk({sck_oe_n, sdo_oe_n, sel_oe_n}, '0, "push pull enables");
      chk({sck_w, sel_w}, {cfg[10], 5'h1F}, "idle levels");
      $display("test transfer %0d done", i);
    end
    // slowest rate cannot finish inside the shortened limit; busy bit write is ignored
    wr(A_CTRL, 32'h000F2121, OK);
    wait_irq();
    rd(A_ST, OK, v);
    chk(v[1], 1'b1, "timeout status");
    rd(A_CTRL, OK, v);
    chk(v[13:8], 6'h02, "timeout flag, idle");
    wr(A_MASK, 32'h00000000, OK);
    chk(irq, 1'b0, "masked");
    wr(A_MASK, 32'h00000002, OK);
    chk(irq, 1'b1, "unmasked timeout");
    wr(A_ST, 32'h00000007, OK);
    chk(irq, 1'b0, "status cleared");
    $display("test timeout and mask done");
    end_sim();
  end
endmodule
